// ===== hw/tpb_top.sv
`timescale 1ns/1ns
module tpb_top
  import tpb_pkg::*;
#(
  parameter int SEQ_LEN = SEQ_BITS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Management register port
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  // Packet self-test engine
  input  wire logic        i_bist_start,
  input  wire logic        i_bist_enable,
  input  wire logic        i_bist_active,
  input  wire logic        i_bist_nibble_err,
  output logic             o_selftest_continuous_tx,
  // 10BASE-T controls
  input  wire logic        i_speed_10m,
  input  wire logic        i_long_tx_guard_disable,
  output logic             o_long_tx_guard_on,
  // Line driver
  input  wire logic        i_drv_bit_tick,
  output logic             o_drv_active,
  output logic             o_drv_bit_valid,
  output logic             o_drv_bit,
  output logic [1:0]       o_drv_eop,
  output logic             o_drv_nlp
);

  // Control fields
  logic               selftest_continuous_tx;
  logic               driver_pattern_enable_10m;
  logic               pattern_sequence_gap_select;
  tpb_pattern_t       driver_pattern_select;
  logic [TALLY_W-1:0] selftest_nibble_error_tally;

  tpb_state_t         state;
  tpb_state_t         next_state;
  logic [8:0]         prbs;
  logic [6:0]         bit_cnt;
  logic               gap_done;
  logic [GAP_W-1:0]   gap_seen;

  // Register decode
  wire logic hit    = (i_reg_addr == EXT_REG_ADDR);
  wire logic wr_hit = hit && i_reg_wr;
  wire logic rd_hit = hit && i_reg_rd;

  // Reserved bits 7:6 and 3 are not stored and read as zero
  wire logic [15:0] reg_value = {selftest_nibble_error_tally, 2'b00,
    selftest_continuous_tx, driver_pattern_enable_10m, 1'b0,
    pattern_sequence_gap_select, driver_pattern_select};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      selftest_continuous_tx      <= 1'b0;
      driver_pattern_enable_10m   <= 1'b0;
      pattern_sequence_gap_select <= 1'b0;
      driver_pattern_select       <= PAT_DATA_EOP0;
    end else if (wr_hit) begin
      selftest_continuous_tx      <= i_reg_wdata[CONT_BIT];
      driver_pattern_enable_10m   <= i_reg_wdata[PATT_EN_BIT];
      pattern_sequence_gap_select <= i_reg_wdata[GAP_SEL_BIT];
      driver_pattern_select       <=
        tpb_pattern_t'(i_reg_wdata[SEL_LSB +: 2]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= RDATA_RESET;
    end else begin
      o_reg_rdata <= rd_hit ? reg_value : RDATA_RESET;
    end
  end

  // Tally: an error in the restart cycle still counts as the first one
  wire logic tally_full = (selftest_nibble_error_tally == TALLY_MAX);
  wire logic count_err  = i_bist_active && i_bist_nibble_err;
  wire logic [TALLY_W-1:0] next_tally =
    i_bist_start ? {{(TALLY_W-1){1'b0}}, count_err} :
    (count_err && !tally_full) ? selftest_nibble_error_tally + 8'h01 :
    selftest_nibble_error_tally;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      selftest_nibble_error_tally <= TALLY_RESET;
    end else begin
      selftest_nibble_error_tally <= next_tally;
    end
  end

  // Gaps are suppressed only while the self-test engine itself is enabled
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_selftest_continuous_tx <= 1'b0;
      o_long_tx_guard_on       <= 1'b0;
    end else begin
      o_selftest_continuous_tx <= selftest_continuous_tx &&
                                  i_bist_enable;
      o_long_tx_guard_on       <= i_speed_10m &&
                                  !i_long_tx_guard_disable;
    end
  end

  // Pattern sequencer
  wire logic is_tone  = (driver_pattern_select == PAT_TONE);
  wire logic is_nlp   = (driver_pattern_select == PAT_NLP);
  wire logic seq_last = (bit_cnt == 7'(SEQ_LEN - 1));
  wire logic gap_load = (state != ST_GAP) && (next_state == ST_GAP);
  wire logic step     = i_drv_bit_tick;

  always_comb begin
    next_state = state;
    if (!driver_pattern_enable_10m) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: next_state = is_nlp ? ST_GAP : ST_SEND;
        ST_SEND: begin
          if (step && !is_tone && seq_last) begin
            next_state = ST_EOP;
          end
        end
        ST_EOP:  next_state = step ? ST_GAP : ST_EOP;
        ST_GAP:  next_state = gap_done ? ST_IDLE : ST_GAP;
      endcase
    end
  end

  tpb_gap_timer #(
    .W (GAP_W)
  ) i_tpb_gap_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_load  (gap_load),
    .i_count (tpb_gap_cycles(pattern_sequence_gap_select)),
    .o_busy  (),
    .o_done  (gap_done)
  );

  wire logic send_bit = (state == ST_SEND) && step;
  wire logic [1:0] eop_code =
    (driver_pattern_select == PAT_DATA_EOP1) ? EOP_ONE : EOP_ZERO;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state           <= ST_IDLE;
      prbs            <= PRBS_SEED;
      bit_cnt         <= '0;
      o_drv_active    <= 1'b0;
      o_drv_bit_valid <= 1'b0;
      o_drv_bit       <= 1'b0;
      o_drv_eop       <= EOP_NONE;
      o_drv_nlp       <= 1'b0;
    end else begin
      state           <= next_state;
      o_drv_active    <= driver_pattern_enable_10m;
      o_drv_bit_valid <= send_bit;
      o_drv_bit       <= send_bit ? (is_tone | prbs[0]) : 1'b0;
      o_drv_eop       <= (state == ST_EOP && step && driver_pattern_enable_10m)
                         ? eop_code : EOP_NONE;
      o_drv_nlp       <= (state == ST_IDLE) && driver_pattern_enable_10m
                         && is_nlp;
      if (send_bit) begin
        prbs    <= {prbs[4] ^ prbs[0], prbs[8:1]};
        bit_cnt <= seq_last ? '0 : bit_cnt + 7'h01;
      end else if (state == ST_IDLE) begin
        bit_cnt <= '0;
      end
    end
  end

  // Helper: cycles spent in the gap state
  always_ff @(posedge i_clk) begin
    if (i_reset || state != ST_GAP) begin
      gap_seen <= '0;
    end else begin
      gap_seen <= gap_seen + 9'h001;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_tally_restart: assert property (
    i_bist_start && !count_err |=> selftest_nibble_error_tally == 8'h00)
    else $error("tally not cleared on restart");
  a_tally_sticks: assert property (
    tally_full && !i_bist_start |=> tally_full)
    else $error("tally wrapped past maximum");
  a_tally_counts: assert property (
    count_err && !i_bist_start && !tally_full |=>
    selftest_nibble_error_tally == $past(selftest_nibble_error_tally) + 8'h01)
    else $error("tally missed an error");
  a_tally_readback: assert property (
    rd_hit |=> o_reg_rdata[TALLY_LSB +: TALLY_W] ==
               $past(selftest_nibble_error_tally)
               && o_reg_rdata[7:6] == 2'b00 && !o_reg_rdata[3])
    else $error("register readback wrong");
  a_cont_follows: assert property (
    ##1 o_selftest_continuous_tx ==
    $past(selftest_continuous_tx && i_bist_enable))
    else $error("continuous output wrong");
  a_pattern_off: assert property (
    !driver_pattern_enable_10m |=> state == ST_IDLE && !o_drv_nlp
                                   && o_drv_eop == EOP_NONE)
    else $error("pattern active while disabled");
  a_gap_length: assert property (
    state == ST_GAP && next_state == ST_IDLE && driver_pattern_enable_10m
    |-> gap_seen == (pattern_sequence_gap_select ? GAP_LONG_CYC
                                                 : GAP_SHORT_CYC))
    else $error("gap length wrong");
  a_tone_ones: assert property (
    send_bit && is_tone |=> o_drv_bit_valid && o_drv_bit)
    else $error("tone bit not one");
  a_guard_state: assert property (
    ##1 o_long_tx_guard_on == $past(i_speed_10m && !i_long_tx_guard_disable))
    else $error("jabber guard wrong");
  a_reset_ctrl: assert property (
    $fell(i_reset) |-> !driver_pattern_enable_10m && !selftest_continuous_tx)
    else $error("control not reset");

  c_tally_full: cover property (tally_full);
  c_eop_one: cover property (o_drv_eop == EOP_ONE);
  c_nlp_long_gap: cover property (o_drv_nlp && pattern_sequence_gap_select);
  c_continuous: cover property (o_selftest_continuous_tx);

endmodule : tpb_top

// ===== hw/tpb_pkg.sv
package tpb_pkg;

  // Management register map
  localparam logic [4:0]  EXT_REG_ADDR    = 5'h1b;
  localparam int          TALLY_LSB       = 8;
  localparam int          TALLY_W         = 8;
  localparam int          CONT_BIT        = 5;
  localparam int          PATT_EN_BIT     = 4;
  localparam int          GAP_SEL_BIT     = 2;
  localparam int          SEL_LSB         = 0;
  localparam logic [7:0]  TALLY_MAX       = 8'hff;
  localparam logic [7:0]  TALLY_RESET     = 8'h00;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;

  // Timing at the 25 MHz core clock
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          GAP_SHORT_US    = 10;
  localparam int          GAP_LONG_US     = 15;
  localparam int          GAP_W           = 9;
  localparam logic [GAP_W-1:0] GAP_SHORT_CYC =
    GAP_W'(GAP_SHORT_US * 1000 / CLK_PERIOD_NS);
  localparam logic [GAP_W-1:0] GAP_LONG_CYC =
    GAP_W'(GAP_LONG_US * 1000 / CLK_PERIOD_NS);

  // Data test sequence
  localparam int          SEQ_BITS        = 64;
  localparam logic [8:0]  PRBS_SEED       = 9'h1ff;

  // End-of-packet marker codes toward the line driver
  localparam logic [1:0]  EOP_NONE        = 2'h0;
  localparam logic [1:0]  EOP_ZERO        = 2'h1;
  localparam logic [1:0]  EOP_ONE         = 2'h2;

  typedef enum logic [1:0] {
    PAT_DATA_EOP0 = 2'b00,
    PAT_DATA_EOP1 = 2'b01,
    PAT_NLP       = 2'b10,
    PAT_TONE      = 2'b11
  } tpb_pattern_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_EOP  = 2'b10,
    ST_GAP  = 2'b11
  } tpb_state_t;

  function automatic logic [GAP_W-1:0] tpb_gap_cycles(input logic long_gap);
    tpb_gap_cycles = long_gap ? GAP_LONG_CYC : GAP_SHORT_CYC;
  endfunction : tpb_gap_cycles

endpackage : tpb_pkg

// ===== hw/tpb_gap_timer.sv
`timescale 1ns/1ns
module tpb_gap_timer
  import tpb_pkg::*;
#(
  parameter int W = GAP_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // Status
  output logic              o_busy,
  output logic              o_done
);

  logic [W-1:0] count;

  wire logic last = o_busy && (count == W'(1));

  // Done comes i_count cycles after the load edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      // A reload drops any done pulse still due from an abandoned gap
      o_done <= last && !i_load;
      if (i_load) begin
        count  <= i_count;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        count  <= count - W'(1);
        o_busy <= !last;
      end
    end
  end

endmodule : tpb_gap_timer

// ===== verification/tx_test_pattern_bist_ext_test.sv
`timescale 1ns/1ns
module tx_test_pattern_bist_ext_test;
  import tpb_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1;
  logic [4:0]  i_reg_addr = 5'h00;
  logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic        i_bist_start = 1'b0, i_bist_enable = 1'b0;
  logic        i_bist_active = 1'b0, i_bist_nibble_err = 1'b0;
  logic        i_speed_10m = 1'b0, i_long_tx_guard_disable = 1'b0;
  logic        i_drv_bit_tick = 1'b0, pend = 1'b0;
  logic        o_selftest_continuous_tx, o_long_tx_guard_on;
  logic        o_drv_active, o_drv_bit_valid, o_drv_bit, o_drv_nlp;
  logic [1:0]  o_drv_eop, eop_seen;
  logic [15:0] exp_q[$];
  int          fails = 0, n_tests = 0, n, p0, p1, cnt;

  tpb_top i_tpb_top (.i_clk(i_clk), .i_reset(i_reset),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_bist_start(i_bist_start), .i_bist_enable(i_bist_enable),
    .i_bist_active(i_bist_active), .i_bist_nibble_err(i_bist_nibble_err),
    .o_selftest_continuous_tx(o_selftest_continuous_tx),
    .i_speed_10m(i_speed_10m),
    .i_long_tx_guard_disable(i_long_tx_guard_disable),
    .o_long_tx_guard_on(o_long_tx_guard_on),
    .i_drv_bit_tick(i_drv_bit_tick), .o_drv_active(o_drv_active),
    .o_drv_bit_valid(o_drv_bit_valid), .o_drv_bit(o_drv_bit),
    .o_drv_eop(o_drv_eop), .o_drv_nlp(o_drv_nlp));

  always #20 i_clk = ~i_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc

  task automatic wr(input logic [15:0] d);
    i_reg_addr = EXT_REG_ADDR; i_reg_wdata = d; i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(2);
  endtask : wr

  // Each read leaves its expected word behind for the monitor
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    i_reg_addr = a; i_reg_rd = 1'b1; exp_q.push_back(e);
    cyc(1);
    i_reg_rd = 1'b0;
    cyc(1);
  endtask : rd

  task automatic errs(input int k, input logic act);
    i_bist_active = act;
    repeat (k) begin
      i_bist_nibble_err = 1'b1; cyc(1); i_bist_nibble_err = 1'b0; cyc(1);
    end
    i_bist_active = 1'b0;
  endtask : errs

  // Cycles from one link-pulse request to the next, bounded
  task automatic nlp_period(output int p);
    p = 0;
    while (o_drv_nlp !== 1'b1 && p < 2000) begin cyc(1); p++; end
    p = 0;
    do begin cyc(1); p++; end while (o_drv_nlp !== 1'b1 && p < 2000);
  endtask : nlp_period

  always @(posedge i_clk) pend <= i_reg_rd;
  always @(negedge i_clk) begin
    if (pend) check(o_reg_rdata, exp_q.pop_front());
  end

  initial begin
    cyc(60000);
    fails++;
    results();
  end

  initial begin
    void'($urandom(96));
    cyc(10);
    i_reset = 1'b0;
    rd(EXT_REG_ADDR, 16'h0000);
    rd(5'h1a, 16'h0000);
    wr(16'h0037);
    rd(EXT_REG_ADDR, 16'h0037);
    // Continuous self-test at 10 Mb runs with the jabber guard turned off
    i_speed_10m = 1'b1;
    i_long_tx_guard_disable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr({10'h000, i[1], 5'h00});
      i_bist_enable = i[0];
      cyc(2);
      check({15'h0, o_selftest_continuous_tx}, {15'h0, &i[1:0]});
    end
    for (int i = 0; i < 4; i++) begin
      {i_speed_10m, i_long_tx_guard_disable} = i[1:0];
      cyc(2);
      check({15'h0, o_long_tx_guard_on}, {15'h0, i == 2});
    end
    wr(16'h0000);
    i_bist_start = 1'b1; cyc(1); i_bist_start = 1'b0;
    n = $urandom_range(1, 40);
    errs(n, 1'b1);
    errs(5, 1'b0);
    rd(EXT_REG_ADDR, {n[7:0], 8'h00});
    errs(300, 1'b1);
    rd(EXT_REG_ADDR, {TALLY_MAX, 8'h00});
    i_bist_start = 1'b1; cyc(1); i_bist_start = 1'b0; cyc(1);
    rd(EXT_REG_ADDR, 16'h0000);
    // Tone: every requested bit is a one
    wr(16'h0013);
    check({15'h0, o_drv_active}, 16'h0001);
    i_drv_bit_tick = 1'b1; cnt = 0;
    repeat (12) begin
      cyc(1);
      if (o_drv_bit_valid === 1'b1) begin
        cnt++;
        check({15'h0, o_drv_bit}, 16'h0001);
      end
    end
    check({15'h0, cnt > 8}, 16'h0001);
    for (int s = 0; s < 2; s++) begin
      wr(16'h0000);
      check({15'h0, o_drv_active}, 16'h0000);
      wr({11'h000, 3'h4, s[1:0]});
      cnt = 0; eop_seen = 2'h0;
      // Sample first: the first bit already stands when the write returns
      repeat (120) begin
        if (eop_seen == 2'h0 && o_drv_bit_valid === 1'b1) cnt++;
        if (eop_seen == 2'h0 && o_drv_eop !== 2'h0) eop_seen = o_drv_eop;
        cyc(1);
      end
      check({14'h0, eop_seen}, {14'h0, s ? EOP_ONE : EOP_ZERO});
      check(16'(cnt), 16'h0040);
    end
    i_drv_bit_tick = 1'b0;
    wr(16'h0000);
    wr(16'h0012);
    nlp_period(p0);
    wr(16'h0000);
    wr(16'h0016);
    nlp_period(p1);
    check(16'(p1 - p0), 16'h007d);
    check(16'(p0 > 250), 16'h0001);
    results();
  end
endmodule : tx_test_pattern_bist_ext_test
